/* File: rtl/lfbt_top.sv */
// lfbt_top: grouped backlight fade ramp and channel 3/4 blink timers.
// assumes the register port, group select bits and current levels come
// from logic on clk_sys; the current sinks use the level outputs directly.
`timescale 1ns/1ps

// Functional notes
// [R1] fade-out code zero: backlight drops to zero at once, no ramp.
// [R2] fade-out code N gives full-scale time N times 0.3 s.
// [R3] fade-out time is for max code to zero; shorter from lower codes.
// [R4] fade-in code zero: backlight jumps to target at once, no ramp.
// [R5] fade-in code N gives full-scale time N times 0.3 s.
// [R6] fade-in time is for zero to max code; shorter to lower targets.
// [R7] blink off code zero disables blink; else off time N times 0.25 s.
// [R8] blink on code N gives on time (N+1) times 0.125 s.
// [R9] blink settings ignored while the channel belongs to the backlight group.
// [R10] channel 3 and 4 blink registers are read/write and reset to zero.
// [R11] both fade fields are read/write and reset to zero.
// [R12] group select one puts channel in backlight group, zero is individual.
// [R13] blinking alternates programmed current and zero current continuously.
// [R14] fade steps code by one at full-scale time over 63 intervals.
module lfbt_top #(
    parameter int unsigned FADE_STEP_CYCLES = lfbt_pkg::FADE_STEP_CYC,
    parameter int unsigned BLINK_UNIT_CYCLES = lfbt_pkg::BLINK_UNIT_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire lfbt_pkg::lfbt_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic bl_enable,
    input wire logic [5:0] bl_target,
    output logic [5:0] bl_code,
    output logic bl_fading,
    input wire logic ch3_group_select,
    input wire logic ch4_group_select,
    input wire logic [5:0] ch3_level,
    input wire logic [5:0] ch4_level,
    output logic [5:0] ch3_drive,
    output logic [5:0] ch4_drive
);
    // cycles for a 4-bit code times a unit count
    function automatic logic [31:0] periods(input logic [3:0] n, input logic [31:0] unit);
        periods = 32'(n * unit);
    endfunction

    localparam logic [31:0] FADE_STEP = 32'(FADE_STEP_CYCLES);
    localparam logic [31:0] BLINK_UNIT = 32'(BLINK_UNIT_CYCLES);
    localparam logic [31:0] OFF_UNIT = 32'(BLINK_UNIT_CYCLES * lfbt_pkg::OFF_UNITS_PER_CODE);
    // largest on code: its unit count does not fit back into four bits
    localparam logic [3:0] CODE_MAX = 4'hf;

    // register file
    lfbt_pkg::lfbt_fade_t fade_q, fade_d;
    lfbt_pkg::lfbt_blink_t blink_q [lfbt_pkg::NUM_CH];
    lfbt_pkg::lfbt_blink_t blink_d [lfbt_pkg::NUM_CH];
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        fade_d = fade_q;
        blink_d = blink_q;
        rdata_d = rdata_q;
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                lfbt_pkg::ADDR_FADE_TIMES: fade_d = reg_req.wdata; // [R11]
                lfbt_pkg::ADDR_CH3_BLINK: blink_d[0] = reg_req.wdata; // [R10]
                lfbt_pkg::ADDR_CH4_BLINK: blink_d[1] = reg_req.wdata; // [R10]
                default: ;
            endcase
        end
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                lfbt_pkg::ADDR_FADE_TIMES: rdata_d = fade_q;
                lfbt_pkg::ADDR_CH3_BLINK: rdata_d = blink_q[0];
                lfbt_pkg::ADDR_CH4_BLINK: rdata_d = blink_q[1];
                default: rdata_d = lfbt_pkg::READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            fade_q <= lfbt_pkg::REG_RESET; // [R11]
            for (int i = 0; i < lfbt_pkg::NUM_CH; i++) begin
                blink_q[i] <= lfbt_pkg::REG_RESET; // [R10]
            end
            rdata_q <= lfbt_pkg::REG_RESET;
        end else begin
            fade_q <= fade_d;
            blink_q <= blink_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // fade ramp
    logic [5:0] code_q, code_d;
    logic [31:0] step_cnt_q, step_cnt_d;
    logic [5:0] goal;
    logic going_up;
    logic going_down;
    logic [3:0] fade_sel;
    logic [31:0] step_len;

    always_comb begin
        goal = bl_enable ? bl_target : lfbt_pkg::LEVEL_ZERO;
        going_up = goal > code_q;
        going_down = goal < code_q;
        fade_sel = going_up ? fade_q.fade_in : fade_q.fade_out;
        // same interval per code step, so shorter ramps end sooner
        step_len = periods(fade_sel, FADE_STEP); // [R2] [R5] [R3] [R6]
        code_d = code_q;
        step_cnt_d = lfbt_pkg::CNT_ZERO;
        if (going_up || going_down) begin
            if (fade_sel == lfbt_pkg::CODE_ZERO) begin
                code_d = goal; // [R1] [R4]
            end else if (step_cnt_q >= step_len - lfbt_pkg::CNT_ONE) begin
                // a goal change mid-step keeps the count already spent
                code_d = going_up ? code_q + lfbt_pkg::LEVEL_ONE
                                  : code_q - lfbt_pkg::LEVEL_ONE; // [R14]
            end else begin
                step_cnt_d = step_cnt_q + lfbt_pkg::CNT_ONE; // [R14]
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            code_q <= lfbt_pkg::LEVEL_ZERO;
            step_cnt_q <= lfbt_pkg::CNT_ZERO;
        end else begin
            code_q <= code_d;
            step_cnt_q <= step_cnt_d;
        end
    end

    assign bl_code = code_q;
    assign bl_fading = (code_q != goal);

    // blink timers
    logic [lfbt_pkg::NUM_CH-1:0] grp_sel;
    logic [5:0] level [lfbt_pkg::NUM_CH];
    lfbt_pkg::lfbt_phase_t ph_q [lfbt_pkg::NUM_CH];
    lfbt_pkg::lfbt_phase_t ph_d [lfbt_pkg::NUM_CH];
    logic [31:0] bcnt_q [lfbt_pkg::NUM_CH];
    logic [31:0] bcnt_d [lfbt_pkg::NUM_CH];
    logic [5:0] drive_q [lfbt_pkg::NUM_CH];
    logic [5:0] drive_d [lfbt_pkg::NUM_CH];
    logic [31:0] on_len [lfbt_pkg::NUM_CH];
    logic [31:0] off_len [lfbt_pkg::NUM_CH];

    assign grp_sel = {ch4_group_select, ch3_group_select}; // [R12]
    assign level[0] = ch3_level;
    assign level[1] = ch4_level;

    always_comb begin
        for (int i = 0; i < lfbt_pkg::NUM_CH; i++) begin
            on_len[i] = periods(blink_q[i].on_period + lfbt_pkg::CODE_ONE, BLINK_UNIT); // [R8]
            // code 15 on wraps to 0 in 4 bits; restore the sixteenth unit
            if (blink_q[i].on_period == CODE_MAX) begin
                on_len[i] = periods(blink_q[i].on_period, BLINK_UNIT) + BLINK_UNIT; // [R8]
            end
            off_len[i] = periods(blink_q[i].off_period, OFF_UNIT); // [R7]
            ph_d[i] = ph_q[i];
            bcnt_d[i] = bcnt_q[i] + lfbt_pkg::CNT_ONE;
            if (grp_sel[i] || blink_q[i].off_period == lfbt_pkg::CODE_ZERO) begin
                // group use or blink off: steady, restart in on phase
                ph_d[i] = lfbt_pkg::LFBT_ON; // [R9] [R7]
                bcnt_d[i] = lfbt_pkg::CNT_ZERO;
            end else begin
                unique case (ph_q[i])
                    lfbt_pkg::LFBT_ON: begin
                        if (bcnt_q[i] >= on_len[i] - lfbt_pkg::CNT_ONE) begin
                            ph_d[i] = lfbt_pkg::LFBT_OFF; // [R13]
                            bcnt_d[i] = lfbt_pkg::CNT_ZERO;
                        end
                    end
                    lfbt_pkg::LFBT_OFF: begin
                        if (bcnt_q[i] >= off_len[i] - lfbt_pkg::CNT_ONE) begin
                            ph_d[i] = lfbt_pkg::LFBT_ON; // [R13]
                            bcnt_d[i] = lfbt_pkg::CNT_ZERO;
                        end
                    end
                endcase
            end
            drive_d[i] = (ph_d[i] == lfbt_pkg::LFBT_ON) ? level[i] : lfbt_pkg::LEVEL_ZERO; // [R13]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            for (int i = 0; i < lfbt_pkg::NUM_CH; i++) begin
                ph_q[i] <= lfbt_pkg::LFBT_ON;
                bcnt_q[i] <= lfbt_pkg::CNT_ZERO;
                drive_q[i] <= lfbt_pkg::LEVEL_ZERO;
            end
        end else begin
            ph_q <= ph_d;
            bcnt_q <= bcnt_d;
            drive_q <= drive_d;
        end
    end

    // levels pass with one cycle of latency even when not blinking
    assign ch3_drive = drive_q[0];
    assign ch4_drive = drive_q[1];

    // checks
    a_fade_out_skip: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
        (!bl_enable && fade_q.fade_out == lfbt_pkg::CODE_ZERO) |=> bl_code == 6'h00)
        else $error("fade-out disabled but code not zero");

    a_fade_in_skip: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
        (bl_enable && bl_target > bl_code && fade_q.fade_in == lfbt_pkg::CODE_ZERO)
        |=> bl_code == $past(bl_target))
        else $error("fade-in disabled but target not reached at once");

    a_fade_step_one: assert property (@(posedge clk_sys) disable iff (!rstn) // [R14]
        (bl_enable && bl_target > bl_code && fade_q.fade_in != lfbt_pkg::CODE_ZERO)
        |=> (bl_code == $past(bl_code) || bl_code == $past(bl_code) + 6'h01))
        else $error("fade-in moved more than one code");

    a_fade_interval: assert property (@(posedge clk_sys) disable iff (!rstn) // [R2] [R5]
        (going_up || going_down) && fade_sel != lfbt_pkg::CODE_ZERO
        && step_cnt_q < step_len - 32'h0000_0001 |=> $stable(bl_code))
        else $error("fade code moved before its interval ended");

    a_regs_reset: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10] [R11]
        $rose(rstn) |-> (fade_q == 8'h00 && blink_q[0] == 8'h00 && blink_q[1] == 8'h00))
        else $error("timing registers not zero after reset");

    a_reg_readback: assert property (@(posedge clk_sys) disable iff (!rstn) // [R11]
        (reg_req.wr && reg_req.addr == lfbt_pkg::ADDR_FADE_TIMES) ##1
        (reg_req.rd && !reg_req.wr && reg_req.addr == lfbt_pkg::ADDR_FADE_TIMES)
        |=> reg_rdata == $past(reg_req.wdata, 2))
        else $error("fade register read back differs from write");

    a_ch3_readback: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
        (reg_req.wr && reg_req.addr == lfbt_pkg::ADDR_CH3_BLINK) ##1
        (reg_req.rd && !reg_req.wr && reg_req.addr == lfbt_pkg::ADDR_CH3_BLINK)
        |=> reg_rdata == $past(reg_req.wdata, 2))
        else $error("channel 3 blink register read back differs from write");

    a_ch4_readback: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
        (reg_req.wr && reg_req.addr == lfbt_pkg::ADDR_CH4_BLINK) ##1
        (reg_req.rd && !reg_req.wr && reg_req.addr == lfbt_pkg::ADDR_CH4_BLINK)
        |=> reg_rdata == $past(reg_req.wdata, 2))
        else $error("channel 4 blink register read back differs from write");

    a_rdata_holds: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10] [R11]
        !reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    a_fade_out_step: assert property (@(posedge clk_sys) disable iff (!rstn) // [R14]
        (!bl_enable && bl_code != 6'h00 && fade_q.fade_out != lfbt_pkg::CODE_ZERO)
        |=> (bl_code == $past(bl_code) || bl_code == $past(bl_code) - 6'h01))
        else $error("fade-out moved more than one code");

    a_fade_step_due: assert property (@(posedge clk_sys) disable iff (!rstn) // [R14]
        (going_up || going_down) && fade_sel != lfbt_pkg::CODE_ZERO
        && step_cnt_q >= step_len - 32'h0000_0001 |=> bl_code != $past(bl_code))
        else $error("fade code did not step when its interval ended");

    a_code_at_goal: assert property (@(posedge clk_sys) disable iff (!rstn) // [R14]
        !(going_up || going_down) |=> $stable(bl_code))
        else $error("fade code moved while at its goal");

    a_fade_in_target: assert property (@(posedge clk_sys) disable iff (!rstn) // [R6]
        (bl_enable && bl_target > bl_code) |=> bl_code <= $past(bl_target))
        else $error("fade-in overshot its target");

    for (genvar g = 0; g < lfbt_pkg::NUM_CH; g++) begin : g_chk
        a_blink_off_dark: assert property (@(posedge clk_sys) disable iff (!rstn) // [R13]
            ph_q[g] == lfbt_pkg::LFBT_OFF |-> drive_q[g] == 6'h00)
            else $error("channel drives current during off period");

        a_group_ignores: assert property (@(posedge clk_sys) disable iff (!rstn) // [R9]
            grp_sel[g] |=> (drive_q[g] == $past(level[g]) && ph_q[g] == lfbt_pkg::LFBT_ON))
            else $error("grouped channel still blinking");

        a_blink_disabled: assert property (@(posedge clk_sys) disable iff (!rstn) // [R7]
            blink_q[g].off_period == 4'h0 |=> drive_q[g] == $past(level[g]))
            else $error("blink disabled but channel not steady");

        a_on_period_len: assert property (@(posedge clk_sys) disable iff (!rstn) // [R8]
            (ph_q[g] == lfbt_pkg::LFBT_ON && !grp_sel[g] && blink_q[g].off_period != 4'h0
            && bcnt_q[g] < on_len[g] - 32'h0000_0001) |=> ph_q[g] == lfbt_pkg::LFBT_ON)
            else $error("on period ended early");

        a_off_period_len: assert property (@(posedge clk_sys) disable iff (!rstn) // [R7]
            (ph_q[g] == lfbt_pkg::LFBT_OFF && !grp_sel[g] && blink_q[g].off_period != 4'h0
            && bcnt_q[g] < off_len[g] - 32'h0000_0001) |=> ph_q[g] == lfbt_pkg::LFBT_OFF)
            else $error("off period ended early");

        a_on_drives_level: assert property (@(posedge clk_sys) disable iff (!rstn) // [R13]
            (ph_q[g] == lfbt_pkg::LFBT_OFF) ##1 (ph_q[g] == lfbt_pkg::LFBT_ON)
            |-> drive_q[g] == $past(level[g]))
            else $error("channel not at its level after the off period");

        a_blink_restart: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
            $rose(rstn) |-> (ph_q[g] == lfbt_pkg::LFBT_ON && bcnt_q[g] == 32'h0000_0000))
            else $error("blink timer not restarted by reset");
    end
endmodule // lfbt_top

/* File: rtl/lfbt_pkg.sv */
// lfbt_pkg: constants and types for the led fade and blink timing block.
// assumes a 100 MHz system clock and a byte-wide register port.
package lfbt_pkg;
    // register offsets
    localparam logic [7:0] ADDR_FADE_TIMES = 8'h2d;
    localparam logic [7:0] ADDR_CH3_BLINK = 8'h2e;
    localparam logic [7:0] ADDR_CH4_BLINK = 8'h2f;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // time bases, printed unit first, cycle counts derived from the clock
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned FADE_UNIT_MS = 300;
    localparam int unsigned BLINK_UNIT_MS = 125;
    localparam int unsigned FADE_STEPS = 63;
    localparam int unsigned OFF_UNITS_PER_CODE = 2;
    localparam int unsigned FADE_UNIT_CYC = FADE_UNIT_MS * 1000 * CLK_MHZ;
    // round down: one step is the longest time that still fits the ramp
    localparam int unsigned FADE_STEP_CYC = FADE_UNIT_CYC / FADE_STEPS;
    localparam int unsigned BLINK_UNIT_CYC = BLINK_UNIT_MS * 1000 * CLK_MHZ;

    localparam int unsigned NUM_CH = 2;
    localparam logic [3:0] CODE_ZERO = 4'h0;
    localparam logic [3:0] CODE_ONE = 4'h1;
    localparam logic [5:0] LEVEL_ZERO = 6'h00;
    localparam logic [5:0] LEVEL_ONE = 6'h01;
    localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;

    typedef struct packed {
        logic [3:0] fade_out;
        logic [3:0] fade_in;
    } lfbt_fade_t;

    typedef struct packed {
        logic [3:0] off_period;
        logic [3:0] on_period;
    } lfbt_blink_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lfbt_req_t;

    typedef enum logic {LFBT_ON, LFBT_OFF} lfbt_phase_t;
endpackage

/* File: sim/lfbt_top_tb.sv */
// lfbt_top_tb: register, fade ramp and blink timing checks for lfbt_top.
// assumes shortened counts: fade step 4 cycles, blink unit 2 cycles.
`timescale 1ns/1ps
module lfbt_top_tb;
    localparam int unsigned STEP = 4;
    localparam int unsigned UNIT = 2;
    logic clk_sys;
    logic rstn;
    lfbt_pkg::lfbt_req_t reg_req;
    logic [7:0] reg_rdata;
    logic bl_enable;
    logic [5:0] bl_target;
    logic [5:0] bl_code;
    logic bl_fading;
    logic ch3_group_select;
    logic ch4_group_select;
    logic [5:0] ch3_level;
    logic [5:0] ch4_level;
    logic [5:0] ch3_drive;
    logic [5:0] ch4_drive;
    int mismatches;
    int compares;
    int cycles;
    int n;
    int chg;
    int on_n;
    int off_n;
    logic fad;
    logic [7:0] v;

    lfbt_top #(.FADE_STEP_CYCLES(STEP), .BLINK_UNIT_CYCLES(UNIT)) uut (
        .clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .bl_enable(bl_enable), .bl_target(bl_target), .bl_code(bl_code),
        .bl_fading(bl_fading), .ch3_group_select(ch3_group_select),
        .ch4_group_select(ch4_group_select), .ch3_level(ch3_level),
        .ch4_level(ch4_level), .ch3_drive(ch3_drive), .ch4_drive(ch4_drive));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // the whole run needs a few hundred cycles; this leaves ample margin
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= {1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        reg_req <= '0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        reg_req <= '0;
        #1 d = reg_rdata;
    endtask

    // write then read the same address on the next edge, no idle cycle between
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        reg_req <= {1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        reg_req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        reg_req <= '0;
        #1 q = reg_rdata;
    endtask

    // counts edges until the ramp settles and how many code changes it took
    task automatic settle();
        logic [5:0] prev;
        prev = bl_code;
        n = 0;
        chg = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
            if (n == 1) fad = bl_fading;
            if (bl_code !== prev) chg++;
            prev = bl_code;
        end while ((bl_fading !== 1'b0) && n < 2000);
    endtask

    task automatic fade(input logic en, input logic [5:0] tgt);
        @(posedge clk_sys);
        bl_enable <= en;
        bl_target <= tgt;
        settle();
    endtask

    function automatic logic [5:0] drv(input logic ch);
        return ch ? ch4_drive : ch3_drive;
    endfunction

    // on and off run lengths after the next off-to-on transition
    task automatic blink(input logic ch);
        int i;
        i = 0;
        on_n = 0;
        off_n = 0;
        while (drv(ch) !== 6'h00 && i < 200) begin @(posedge clk_sys); #1 i++; end
        while (drv(ch) === 6'h00 && i < 400) begin @(posedge clk_sys); #1 i++; end
        while (drv(ch) !== 6'h00 && i < 600) begin @(posedge clk_sys); #1 i++; on_n++; end
        while (drv(ch) === 6'h00 && i < 800) begin @(posedge clk_sys); #1 i++; off_n++; end
    endtask

    // cycles over a span longer than the off phases programmed here where drive is not the level
    task automatic steady(input logic ch, input logic [5:0] lvl);
        int bad;
        bad = 0;
        repeat (3) @(posedge clk_sys);
        repeat (40) begin
            @(posedge clk_sys);
            #1 if (drv(ch) !== lvl) bad++;
        end
        check(8'(bad), 8'h00);
    endtask

    initial begin
        rstn = 1'b0;
        reg_req = '0;
        bl_enable = 1'b0;
        bl_target = 6'h00;
        ch3_group_select = 1'b0;
        ch4_group_select = 1'b0;
        ch3_level = 6'h05;
        ch4_level = 6'h2a;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        rd_reg(8'h2d, v);
        check(v, 8'h00);
        rd_reg(8'h2e, v);
        check(v, 8'h00);
        rd_reg(8'h2f, v);
        check(v, 8'h00);
        wr_reg(8'h2d, 8'ha5);
        wr_reg(8'h2e, 8'h3c);
        wr_reg(8'h2f, 8'hc3);
        wr_reg(8'h30, 8'hff);
        rd_reg(8'h2d, v);
        check(v, 8'ha5);
        rd_reg(8'h2e, v);
        check(v, 8'h3c);
        rd_reg(8'h2f, v);
        check(v, 8'hc3);
        rd_reg(8'h30, v);
        check(v, 8'h00);
        wr_rd(8'h2d, 8'h5a, v);
        check(v, 8'h5a);
        wr_rd(8'h2e, 8'h96, v);
        check(v, 8'h96);
        wr_rd(8'h2f, 8'h69, v);
        check(v, 8'h69);
        $display("test registers done");
        // fade-in 2 and fade-out 1; target 3 ends sooner than full scale
        wr_reg(8'h2d, 8'h12);
        wr_reg(8'h2e, 8'h00);
        wr_reg(8'h2f, 8'h00);
        fade(1'b1, 6'h03);
        check(8'(bl_code), 8'h03);
        check(8'(chg), 8'h03);
        check(8'(n >= 3 * 2 * STEP && n <= 3 * 2 * STEP + 2), 8'h01);
        check(8'(fad), 8'h01);
        check(8'(bl_fading), 8'h00);
        fade(1'b0, 6'h03);
        check(8'(bl_code), 8'h00);
        check(8'(chg), 8'h03);
        check(8'(n >= 3 * STEP && n <= 3 * STEP + 2), 8'h01);
        check(8'(fad), 8'h01);
        check(8'(bl_fading), 8'h00);
        wr_reg(8'h2d, 8'h00);
        fade(1'b1, 6'h2a);
        check(8'(bl_code), 8'h2a);
        check(8'(chg), 8'h01);
        check(8'(fad), 8'h00);
        fade(1'b0, 6'h2a);
        check(8'(bl_code), 8'h00);
        check(8'(chg), 8'h01);
        check(8'(fad), 8'h00);
        $display("test fade done");
        wr_reg(8'h2e, 8'h21);
        wr_reg(8'h2f, 8'h1f);
        blink(1'b0);
        check(8'(on_n), 8'(2 * UNIT));
        check(8'(off_n), 8'(2 * 2 * UNIT));
        blink(1'b0);
        check(8'(on_n), 8'(2 * UNIT));
        blink(1'b1);
        check(8'(on_n), 8'(16 * UNIT));
        check(8'(off_n), 8'(2 * UNIT));
        check(8'(ch4_drive), 8'h2a);
        @(posedge clk_sys);
        ch3_group_select <= 1'b1;
        steady(1'b0, 6'h05);
        @(posedge clk_sys);
        ch3_group_select <= 1'b0;
        blink(1'b0);
        check(8'(off_n), 8'(2 * 2 * UNIT));
        wr_reg(8'h2f, 8'h0f);
        steady(1'b1, 6'h2a);
        $display("test blink done");
        // reset in mid-run must clear written registers and stop blinking
        wr_reg(8'h2d, 8'h12);
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        rd_reg(8'h2d, v);
        check(v, 8'h00);
        rd_reg(8'h2e, v);
        check(v, 8'h00);
        rd_reg(8'h2f, v);
        check(v, 8'h00);
        steady(1'b0, 6'h05);
        $display("test reset done");
        report_and_stop();
    end
endmodule // lfbt_top_tb
